// ---- utx_pkg.sv ----
/*
  Constants, register map and state types of the UART transmitter.
  Assumes a single 25 MHz clock and an AXI4-Lite master of 32-bit data.
*/
// Function
// - Transmitter on takes over serial output pin
// - Synchronous master mode takes over transfer clock pin
// - Data register write loads buffer, starts sending
// - Buffer moves to shifter when idle or after stop
// - Shifter sends one frame at selected bit rate
// - Data bits above character size ignored
// - Ninth bit taken from control bit
// - Buffer empty flag follows buffer state
// - Data register write clears buffer empty flag
// - Buffer empty interrupt requested while flag set
// - Complete flag set when frame done, buffer empty
// - Complete flag cleared by service or one-write
// - Complete interrupt requested while flag set
// - Parity bit inserted before first stop bit
// - Disable waits until shifter and buffer empty
// - Disabled transmitter releases serial output pin
// - Start low, data LSB first, parity, stops high
// - Five to nine bits, parity, one/two stops
// - Parity is data XOR, inverted for odd
// - Clock polarity picks data change edge
package utx_pkg;
    localparam int CLK_HZ = 25000000;
    localparam int AW     = 5;

    localparam logic [AW-1:0] OFS_DATA   = 5'h00;
    localparam logic [AW-1:0] OFS_STAT_A = 5'h04;
    localparam logic [AW-1:0] OFS_CTRL_B = 5'h08;
    localparam logic [AW-1:0] OFS_CTRL_C = 5'h0C;
    localparam logic [AW-1:0] OFS_BAUD   = 5'h10;

    // Status register A
    localparam int A_TXC = 6;
    localparam int A_UDR = 5;
    localparam int A_DBL = 1;
    // Control register B
    localparam int B_TXCIE = 6;
    localparam int B_UDRIE = 5;
    localparam int B_ON    = 3;
    localparam int B_SIZE2 = 2;
    localparam int B_NINTH = 0;
    // Control register C
    localparam int C_MODE = 6;
    localparam int C_PAR  = 4;
    localparam int C_STOP = 3;
    localparam int C_SIZE = 1;
    localparam int C_POL  = 0;

    localparam logic [1:0] MODE_SYNC = 2'h1;
    localparam logic [3:0] SUB_NORM  = 4'hF;
    localparam logic [3:0] SUB_DBL   = 4'h7;
    localparam logic [1:0] RESP_OK   = 2'h0;
    localparam logic [1:0] RESP_ERR  = 2'h2;

    typedef enum logic [1:0] {
        UTX_OFF   = 2'h0,
        UTX_IDLE  = 2'h1,
        UTX_SHIFT = 2'h3
    } utx_state_t;

    typedef struct packed {
        logic out;
        logic oe_n;
    } utx_pin_t;

    typedef struct packed {
        utx_state_t  state;
        logic [12:0] frame;
        logic [3:0]  bits_left;
        logic        tx_line;
        logic [7:0]  buf_data;
        logic        buf_bit8;
        logic        buf_empty;
        logic        txc;
        logic        dbl;
        logic [6:0]  ctrl_b;
        logic [7:0]  ctrl_c;
        logic [11:0] baud;
        logic [11:0] prescale;
        logic [3:0]  sub;
        logic        xck;
        logic        xck_prev;
        logic        aw_got;
        logic [AW-1:0] waddr;
        logic        w_got;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } utx_regs_t;

    localparam utx_regs_t UTX_RESET = '{
        state: UTX_OFF, tx_line: 1'h1, buf_empty: 1'h1, default: '0};
endpackage

// ---- utx_uart_transmitter.sv ----
/*
  Transmit half of a serial port with an AXI4-Lite register slave.
  Assumes all inputs synchronous to aclk; the port logic outside muxes
  the pins by the active-low enables.
*/
// Local design decisions: the AXI4-Lite register port and the register addresses.
`timescale 1ns/1ps
module utx_uart_transmitter (
    input  wire logic                 aclk,
    input  wire logic                 aresetn,
    input  wire logic [utx_pkg::AW-1:0] s_axi_awaddr,
    input  wire logic                 s_axi_awvalid,
    output logic                      s_axi_awready,
    input  wire logic [31:0]          s_axi_wdata,
    input  wire logic [3:0]           s_axi_wstrb,
    input  wire logic                 s_axi_wvalid,
    output logic                      s_axi_wready,
    output logic [1:0]                s_axi_bresp,
    output logic                      s_axi_bvalid,
    input  wire logic                 s_axi_bready,
    input  wire logic [utx_pkg::AW-1:0] s_axi_araddr,
    input  wire logic                 s_axi_arvalid,
    output logic                      s_axi_arready,
    output logic [31:0]               s_axi_rdata,
    output logic [1:0]                s_axi_rresp,
    output logic                      s_axi_rvalid,
    input  wire logic                 s_axi_rready,
    input  wire logic                 global_irq_en,
    input  wire logic                 tx_complete_irq_ack,
    input  wire logic                 xfer_clock_master,
    input  wire logic                 xfer_clock_pin_in,
    output utx_pkg::utx_pin_t         xfer_clock_pin,
    output utx_pkg::utx_pin_t         serial_out_pin,
    output logic                      buffer_empty_irq,
    output logic                      tx_complete_irq
);
    import utx_pkg::*;

    utx_regs_t r;
    utx_regs_t next_r;

    logic       sync_mode;
    logic       bit_tick;
    logic       pre_zero;
    logic [3:0] n_bits;
    logic       move;
    logic       txc_set;
    logic       wr_do;
    logic       data_wr;

    function automatic logic mapped(input logic [AW-1:0] a);
        return a == OFS_DATA || a == OFS_STAT_A || a == OFS_CTRL_B ||
               a == OFS_CTRL_C || a == OFS_BAUD;
    endfunction

    function automatic logic [3:0] size_bits(input logic [2:0] s);
        if (s == 3'h7) begin
            return 4'h9;
        end else if (s[2] == 1'h0) begin
            return 4'h5 + {2'h0, s[1:0]};
        end
        return 4'h8;
    endfunction

    function automatic logic [12:0] build(input logic [8:0] d,
                                          input logic [3:0] n,
                                          input logic       pe,
                                          input logic       odd);
        logic [12:0] f;
        logic        p;
        f = '1;
        p = odd;
        f[0] = 1'h0;
        for (int i = 0; i < 9; i++) begin
            if (i < int'(n)) begin
                f[i+1] = d[i];
                p = p ^ d[i];
            end
        end
        if (pe) begin
            f[n+4'h1] = p;
        end
        return f;
    endfunction

    assign sync_mode = r.ctrl_c[C_MODE+:2] == MODE_SYNC;
    assign pre_zero  = r.prescale == 12'h000;
    assign n_bits    = size_bits({r.ctrl_b[B_SIZE2], r.ctrl_c[C_SIZE+:2]});
    assign wr_do     = r.aw_got && r.w_got && !r.bvalid;
    assign data_wr   = wr_do && r.waddr == OFS_DATA && r.wstrb[0];

    // Bit pacing: divider, double speed or transfer clock edge
    always_comb begin
        if (!sync_mode) begin
            bit_tick = pre_zero && r.sub == (r.dbl ? SUB_DBL : SUB_NORM);
        end else if (xfer_clock_master) begin
            bit_tick = pre_zero && r.xck == r.ctrl_c[C_POL];
        end else begin
            bit_tick = xfer_clock_pin_in != r.xck_prev &&
                       xfer_clock_pin_in != r.ctrl_c[C_POL];
        end
    end

    assign s_axi_awready = !r.aw_got;
    assign s_axi_wready  = !r.w_got;
    assign s_axi_arready = !r.rvalid;
    assign s_axi_bvalid  = r.bvalid;
    assign s_axi_bresp   = r.bresp;
    assign s_axi_rvalid  = r.rvalid;
    assign s_axi_rdata   = r.rdata;
    assign s_axi_rresp   = r.rresp;

    assign serial_out_pin.out  = r.tx_line;
    assign serial_out_pin.oe_n = r.state == UTX_OFF;
    assign xfer_clock_pin.out  = r.xck;
    assign xfer_clock_pin.oe_n = !(sync_mode && xfer_clock_master &&
                                   r.state != UTX_OFF);

    assign buffer_empty_irq = r.ctrl_b[B_UDRIE] && global_irq_en && r.buf_empty;
    assign tx_complete_irq  = r.ctrl_b[B_TXCIE] && global_irq_en && r.txc;

    always_comb begin
        next_r = r;
        move = 1'h0;
        txc_set = 1'h0;

        // Divider and transfer clock
        next_r.xck_prev = xfer_clock_pin_in;
        next_r.prescale = pre_zero ? r.baud : r.prescale - 12'h001;
        if (pre_zero) begin
            next_r.sub = r.sub == (r.dbl ? SUB_DBL : SUB_NORM) ? 4'h0 : r.sub + 4'h1;
            if (sync_mode && xfer_clock_master) begin
                next_r.xck = !r.xck;
            end
        end

        // Frame sequencer
        case (r.state)
            UTX_OFF: begin
                if (r.ctrl_b[B_ON]) begin
                    next_r.state = UTX_IDLE;
                end
            end
            UTX_IDLE: begin
                if (bit_tick && !r.buf_empty) begin
                    move = 1'h1;
                end else if (!r.ctrl_b[B_ON] && r.buf_empty) begin
                    next_r.state = UTX_OFF;
                end
            end
            UTX_SHIFT: begin
                if (bit_tick) begin
                    if (r.bits_left == 4'h1) begin
                        if (!r.buf_empty) begin
                            move = 1'h1;
                        end else begin
                            txc_set = 1'h1;
                            next_r.tx_line = 1'h1;
                            next_r.state = r.ctrl_b[B_ON] ? UTX_IDLE : UTX_OFF;
                        end
                    end else begin
                        next_r.frame = {1'h1, r.frame[12:1]};
                        next_r.tx_line = r.frame[1];
                        next_r.bits_left = r.bits_left - 4'h1;
                    end
                end
            end
            default: begin
                next_r.state = UTX_OFF;
            end
        endcase

        if (move) begin
            // Bits above the size never enter the frame
            next_r.frame = build({r.buf_bit8, r.buf_data}, n_bits,
                                 r.ctrl_c[C_PAR+1], r.ctrl_c[C_PAR]);
            next_r.bits_left = 4'h2 + n_bits + {3'h0, r.ctrl_c[C_PAR+1]} +
                               {3'h0, r.ctrl_c[C_STOP]};
            next_r.tx_line = 1'h0;
            next_r.state = UTX_SHIFT;
            next_r.buf_empty = 1'h1;
        end

        // Register writes
        if (s_axi_awvalid && !r.aw_got) begin
            next_r.aw_got = 1'h1;
            next_r.waddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !r.w_got) begin
            next_r.w_got = 1'h1;
            next_r.wdata = s_axi_wdata;
            next_r.wstrb = s_axi_wstrb;
        end
        if (wr_do) begin
            next_r.bvalid = 1'h1;
            next_r.bresp = mapped(r.waddr) ? RESP_OK : RESP_ERR;
            if (r.wstrb[0]) begin
                case (r.waddr)
                    OFS_DATA: begin
                        next_r.buf_data = r.wdata[7:0];
                        next_r.buf_bit8 = r.ctrl_b[B_NINTH];
                        next_r.buf_empty = 1'h0;
                    end
                    OFS_STAT_A: next_r.dbl = r.wdata[A_DBL];
                    OFS_CTRL_B: next_r.ctrl_b = r.wdata[6:0];
                    OFS_CTRL_C: next_r.ctrl_c = r.wdata[7:0];
                    OFS_BAUD:   next_r.baud[7:0] = r.wdata[7:0];
                    default: begin
                    end
                endcase
            end
            if (r.wstrb[1] && r.waddr == OFS_BAUD) begin
                next_r.baud[11:8] = r.wdata[11:8];
            end
        end
        if (r.bvalid && s_axi_bready) begin
            next_r.bvalid = 1'h0;
            next_r.aw_got = 1'h0;
            next_r.w_got = 1'h0;
        end

        // Complete flag: set beats clear
        if (txc_set) begin
            next_r.txc = 1'h1;
        end else if (tx_complete_irq_ack || (wr_do && r.waddr == OFS_STAT_A &&
                     r.wstrb[0] && r.wdata[A_TXC])) begin
            next_r.txc = 1'h0;
        end

        // Register reads
        if (s_axi_arvalid && !r.rvalid) begin
            next_r.rvalid = 1'h1;
            next_r.rresp = mapped(s_axi_araddr) ? RESP_OK : RESP_ERR;
            next_r.rdata = 32'h0000_0000;
            case (s_axi_araddr)
                OFS_DATA:   next_r.rdata[7:0] = r.buf_data;
                OFS_STAT_A: begin
                    next_r.rdata[A_TXC] = r.txc;
                    next_r.rdata[A_UDR] = r.buf_empty;
                    next_r.rdata[A_DBL] = r.dbl;
                end
                OFS_CTRL_B: next_r.rdata[6:0] = r.ctrl_b;
                OFS_CTRL_C: next_r.rdata[7:0] = r.ctrl_c;
                OFS_BAUD:   next_r.rdata[11:0] = r.baud;
                default: begin
                end
            endcase
        end else if (r.rvalid && s_axi_rready) begin
            next_r.rvalid = 1'h0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            r <= UTX_RESET;
        end else begin
            r <= next_r;
        end
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    property p_take_pin;
        $rose(r.ctrl_b[B_ON]) && r.state == UTX_OFF |=> !serial_out_pin.oe_n;
    endproperty
    a_take_pin: assert property (p_take_pin)
        else $error("serial pin not taken over");

    property p_release_pin;
        r.state == UTX_OFF |-> serial_out_pin.oe_n && xfer_clock_pin.oe_n;
    endproperty
    a_release_pin: assert property (p_release_pin)
        else $error("pins driven while disabled");

    property p_write_fills;
        data_wr |=> !r.buf_empty ##1 1'h1;
    endproperty
    a_write_fills: assert property (p_write_fills)
        else $error("buffer empty flag not cleared by data write");

    property p_move;
        r.state == UTX_IDLE && bit_tick && !r.buf_empty && !data_wr
            |=> r.state == UTX_SHIFT && r.buf_empty && !serial_out_pin.out;
    endproperty
    a_move: assert property (p_move)
        else $error("buffer not moved into idle shifter");

    property p_done;
        r.state == UTX_SHIFT && bit_tick && r.bits_left == 4'h1 && r.buf_empty
            |=> r.txc && serial_out_pin.out;
    endproperty
    a_done: assert property (p_done)
        else $error("complete flag not set after last stop bit");

    property p_ack;
        tx_complete_irq_ack && !txc_set |=> !r.txc;
    endproperty
    a_ack: assert property (p_ack)
        else $error("complete flag not cleared on service");

    property p_hold_on;
        !r.ctrl_b[B_ON] && !r.buf_empty && r.state != UTX_OFF |=> r.state != UTX_OFF;
    endproperty
    a_hold_on: assert property (p_hold_on)
        else $error("transmitter stopped with pending data");

    property p_empty_irq;
        r.buf_empty && r.ctrl_b[B_UDRIE] && global_irq_en |-> buffer_empty_irq;
    endproperty
    a_empty_irq: assert property (p_empty_irq)
        else $error("buffer empty request missing");

    property p_edge;
        sync_mode && xfer_clock_master && !r.ctrl_c[C_POL] && $changed(r.tx_line)
            && $past(r.state) == UTX_SHIFT |-> $rose(r.xck);
    endproperty
    a_edge: assert property (p_edge)
        else $error("data changed off the rising clock edge");

    property p_start_stop;
        move |=> !r.tx_line && r.frame[r.bits_left - 4'h1];
    endproperty
    a_start_stop: assert property (p_start_stop)
        else $error("frame lacks start or stop bit");
endmodule // utx_uart_transmitter

// ---- utx_rx_model.sv ----
/* Remote serial receiver model watching the transmit line.
   Assumes an idle-high line and a bit period given in aclk cycles. */
`timescale 1ns/1ps
module utx_rx_model (
    input  wire logic        aclk,
    input  wire logic        line,
    input  wire logic [4:0]  bit_clks,
    input  wire logic [3:0]  nbits,
    input  wire logic        par_en,
    input  wire logic        two_stops,
    output logic             got,
    output logic [10:0]      frame
);
    logic [8:0] d;
    logic       p;
    logic       ok;
    initial begin
        got = 1'h0;
        frame = '0;
        forever begin
            @(negedge line);
            repeat (bit_clks / 2) @(posedge aclk);
            if (line === 1'h0) begin
                d = '0;
                p = 1'h0;
                ok = 1'h1;
                for (int i = 0; i < nbits; i++) begin
                    repeat (bit_clks) @(posedge aclk);
                    d[i] = line;
                end
                if (par_en) begin
                    repeat (bit_clks) @(posedge aclk);
                    p = line;
                end
                repeat (two_stops ? 2 : 1) begin
                    repeat (bit_clks) @(posedge aclk);
                    ok = ok & (line === 1'h1);
                end
                got <= 1'h1;
                frame <= {ok, p, d};
                @(posedge aclk);
                got <= 1'h0;
            end
        end
    end
endmodule // utx_rx_model

// ---- tb.sv ----
/* Self-checking bench: AXI4-Lite tasks, line receiver model, queued results.
   Assumes one 25 MHz clock and a pull-up on the released serial line. */
`timescale 1ns/1ps
module tb;
    import utx_pkg::*;
    logic          aclk, aresetn, gie, ack, empty_irq, done_irq, line;
    logic          awvalid, awready, wvalid, wready, bvalid, bready;
    logic          arvalid, arready, rvalid, rready;
    logic [AW-1:0] awaddr, araddr;
    logic [31:0]   wdata, rdata;
    logic [3:0]    wstrb, nbits;
    logic [1:0]    bresp, rresp;
    logic          got, par_en, odd, two_stops, dbl;
    logic [4:0]    bit_clks;
    logic [10:0]   frame;
    utx_pin_t      txd, xck;
    logic [33:0]   exp_rd[$];
    logic [10:0]   exp_frame[$];
    logic [1:0]    exp_b[$];
    int            mismatches, samples_checked, cycles;

    assign line = txd.oe_n ? 1'h1 : txd.out;

    utx_uart_transmitter utx_uart_transmitter_i (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .global_irq_en(gie),
        .tx_complete_irq_ack(ack), .xfer_clock_master(1'h1), .xfer_clock_pin_in(1'h0),
        .xfer_clock_pin(xck), .serial_out_pin(txd), .buffer_empty_irq(empty_irq),
        .tx_complete_irq(done_irq));

    utx_rx_model utx_rx_model_i (.aclk(aclk), .line(line), .bit_clks(bit_clks),
        .nbits(nbits), .par_en(par_en), .two_stops(two_stops), .got(got), .frame(frame));

    initial begin
        aclk = 1'h0;
        forever #20 aclk = ~aclk;
    end

    task automatic wrap_up();
        mismatches += exp_rd.size() + exp_frame.size() + exp_b.size();
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    task automatic cmp_word(input logic [33:0] act, input logic [33:0] exp);
        samples_checked++;
        if (act !== exp) begin
            mismatches++;
            $display("unexpected at %0t: got %h expected %h", $time, act, exp);
        end
    endtask

    task automatic cmp_frame(input logic [10:0] act, input logic [10:0] exp);
        samples_checked++;
        if (act !== exp) begin
            mismatches++;
            $display("unexpected frame at %0t: got %h expected %h", $time, act, exp);
        end
    endtask

    task automatic wr(input logic [AW-1:0] a, input logic [31:0] d, input logic [1:0] r);
        logic aw_ok, w_ok, b_ok;
        @(posedge aclk);
        exp_b.push_back(r);
        awaddr <= a;
        wdata <= d;
        wstrb <= 4'hF;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        do begin
            // Handshakes judged on settled values before the edge
            @(negedge aclk);
            aw_ok = awvalid && awready;
            w_ok = wvalid && wready;
            b_ok = bvalid && bready;
            @(posedge aclk);
            if (aw_ok) awvalid <= 1'h0;
            if (w_ok) wvalid <= 1'h0;
        end while (!b_ok);
        bready <= 1'h0;
    endtask

    task automatic rd(input logic [AW-1:0] a, input logic [33:0] e);
        logic ar_ok, r_ok;
        @(posedge aclk);
        exp_rd.push_back(e);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        do begin
            @(negedge aclk);
            ar_ok = arvalid && arready;
            r_ok = rvalid && rready;
            @(posedge aclk);
            if (ar_ok) arvalid <= 1'h0;
        end while (!r_ok);
        rready <= 1'h0;
    endtask

    task automatic send(input logic [31:0] b, input logic [8:0] d);
        logic [8:0] m;
        m = d & ~(9'h1FF << nbits);
        wr(OFS_CTRL_B, b | {31'h0, d[8]}, RESP_OK);
        wr(OFS_DATA, {24'($urandom), d[7:0]}, RESP_OK);
        exp_frame.push_back({1'h1, par_en & (^m ^ odd), m});
    endtask

    task automatic wait_frames();
        while (exp_frame.size() != 0) @(posedge aclk);
        repeat (bit_clks) @(posedge aclk);
    endtask

    // Results sampled mid-cycle, where outputs are settled
    always @(negedge aclk) begin
        if (rvalid && rready) cmp_word({rresp, rdata}, exp_rd.pop_front());
        if (bvalid && bready) cmp_word({32'h0, bresp}, {32'h0, exp_b.pop_front()});
        if (got) cmp_frame(frame, exp_frame.pop_front());
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            wrap_up();
        end
    end

    initial begin
        int k;
        logic [2:0] sc;
        {awvalid, wvalid, bready, arvalid, rready, gie, ack} = '0;
        {awaddr, araddr, wdata, wstrb} = '0;
        {par_en, odd, two_stops, dbl} = '0;
        nbits = 4'h8;
        bit_clks = 5'h10;
        mismatches = 0;
        samples_checked = 0;
        cycles = 0;
        aresetn = 1'h0;
        void'($urandom(38224));
        repeat (4) @(posedge aclk);
        aresetn <= 1'h1;
        rd(OFS_STAT_A, {RESP_OK, 32'h20});
        cmp_word({33'h0, txd.oe_n}, 34'h1);
        cmp_word({33'h0, xck.oe_n}, 34'h1);
        wr(OFS_BAUD, 32'h0, RESP_OK);
        $display("reset test done");
        for (k = 0; k < 5; k++) begin
            sc = (k == 4) ? 3'h7 : 3'(k);
            nbits = 4'(k + 5);
            par_en = (k % 3) != 0;
            odd = (k % 3) == 2;
            two_stops = k[0];
            dbl = k == 4;
            bit_clks = dbl ? 5'h08 : 5'h10;
            wr(OFS_STAT_A, {30'h0, dbl, 1'h0}, RESP_OK);
            wr(OFS_CTRL_C, {26'h0, par_en, odd, two_stops, sc[1:0], 1'h0}, RESP_OK);
            send({28'h0, 1'h1, sc[2], 2'h0}, 9'($urandom));
            repeat (2 * bit_clks) @(posedge aclk);
            send({28'h0, 1'h1, sc[2], 2'h0}, 9'($urandom));
            rd(OFS_STAT_A, {RESP_OK, 30'h0, dbl, 1'h0});
            wait_frames();
            rd(OFS_STAT_A, {RESP_OK, 32'h60 | {30'h0, dbl, 1'h0}});
            wr(OFS_STAT_A, {25'h0, 1'h1, 4'h0, dbl, 1'h0}, RESP_OK);
            rd(OFS_STAT_A, {RESP_OK, 25'h0, 2'h1, 3'h0, dbl, 1'h0});
            $display("format test %0d done", k);
        end
        nbits = 4'h8;
        wr(OFS_CTRL_B, 32'h28, RESP_OK);
        @(negedge aclk);
        cmp_word({33'h0, empty_irq}, 34'h0);
        @(posedge aclk);
        gie <= 1'h1;
        @(negedge aclk);
        cmp_word({33'h0, empty_irq}, 34'h1);
        send(32'h28, 9'($urandom));
        repeat (2 * bit_clks) @(posedge aclk);
        send(32'h28, 9'($urandom));
        @(negedge aclk);
        cmp_word({33'h0, empty_irq}, 34'h0);
        wr(OFS_CTRL_B, 32'h48, RESP_OK);
        wait_frames();
        @(negedge aclk);
        cmp_word({33'h0, done_irq}, 34'h1);
        @(posedge aclk);
        ack <= 1'h1;
        @(posedge aclk);
        ack <= 1'h0;
        rd(OFS_STAT_A, {RESP_OK, 25'h0, 2'h1, 3'h0, dbl, 1'h0});
        $display("interrupt test done");
        send(32'h08, 9'($urandom));
        @(negedge aclk);
        cmp_word({33'h0, txd.oe_n}, 34'h0);
        repeat (2 * bit_clks) @(posedge aclk);
        wr(OFS_CTRL_B, 32'h0, RESP_OK);
        @(negedge aclk);
        cmp_word({33'h0, txd.oe_n}, 34'h0);
        wait_frames();
        @(negedge aclk);
        cmp_word({33'h0, txd.oe_n}, 34'h1);
        wr(5'h14, 32'h55, RESP_ERR);
        rd(5'h18, {RESP_ERR, 32'h0});
        $display("disable and unmapped test done");
        wrap_up();
    end
endmodule // tb
